// ==== verilog/rbac_rx_bit_align.sv ====
// Behaviour
// RULE1 - zero bits after collision unless keep set
// RULE2 - alignment field sets first bit position
// RULE3 - alignment seven wraps second bit next byte
// RULE4 - zero alignment byte mode, else bit mode
// RULE5 - collision sets integrity error when enabled
// RULE6 - last bits count valid bits, zero whole
// RULE7 - decoder writes last bits, reset at start
// RULE8 - position valid only when in range
// RULE9 - position holds first collision data bit
// RULE10 - position is zero based index across bytes
// RULE11 - report only within first eight bytes
// RULE12 - position includes alignment offset
// RULE13 - host uses position only when valid
// RULE14 - no collision flag inside end symbol
// RULE15 - collision flag cleared at reception start
// RULE16 - position valid cleared at reception start
//
// Register access over AXI4-Lite was chosen for this implementation.
`include "rbac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rbac_rx_bit_align
  import rbac_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rbac_dec_type dec_in,
  output rbac_byte_type byte_out,
  output logic irq
);
  // ****************************************
  // decoder inputs come from the RF front end
  // ****************************************
  rbac_dec_type dec;
  rbac_sync #(.W(7)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(dec_in),
    .q_ff(dec)
  );
  function automatic logic [31:0] widen8(input logic [7:0] v);
    return {24'h000000, v};
  endfunction
  // ****************************************
  // registers and receive state
  // ****************************************
  rbac_state_type state_ff;
  logic keep_values_after_collision_ff, collision_as_integrity_error_ff, coll_seen_ff;
  logic collision_position_valid_ff, collision_detected_ff, data_integrity_error_ff;
  logic [2:0] receive_alignment_ff, last_byte_valid_bits_ff, bpos_ff, mem_raddr_ff;
  logic [6:0] collision_position_ff, bit_idx_ff;
  logic [7:0] shift_ff, mem_rdata;
  // one extra bit marks the byte store as full after eight bytes
  logic [3:0] byte_cnt_ff;
  logic [3:0] irq_status_ff, irq_enable_ff;
  logic frame_arm;
  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic aw_ok_ff, w_ok_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic do_write;
  logic [3:0] irq_clear;
  assign do_write = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
  assign irq_clear = (do_write && awaddr_ff == `RBAC_ADDR_IRQ_CLEAR && wstrb_ff[0])
      ? wdata_ff[3:0] : 4'h0;
  assign frame_arm = do_write && awaddr_ff == `RBAC_ADDR_FRAME_CTRL && wstrb_ff[0]
      && wdata_ff[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_ok_ff && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready <= !w_ok_ff && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= awaddr_ff inside {`RBAC_ADDR_BIT_CONTROL, `RBAC_ADDR_COLL_INFO,
            `RBAC_ADDR_ERROR_FLAGS, `RBAC_ADDR_IRQ_STATUS, `RBAC_ADDR_IRQ_ENABLE,
            `RBAC_ADDR_IRQ_CLEAR, `RBAC_ADDR_FRAME_CTRL} ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `RBAC_ADDR_BIT_CONTROL: s_axi_rdata <= widen8({keep_values_after_collision_ff,
              receive_alignment_ff, collision_as_integrity_error_ff, last_byte_valid_bits_ff});
          `RBAC_ADDR_COLL_INFO: s_axi_rdata <= widen8({collision_position_valid_ff,
              collision_position_ff});
          `RBAC_ADDR_ERROR_FLAGS: s_axi_rdata <= widen8({5'h00, collision_detected_ff,
              1'b0, data_integrity_error_ff});
          `RBAC_ADDR_IRQ_STATUS: s_axi_rdata <= {28'h0000000, irq_status_ff};
          `RBAC_ADDR_IRQ_ENABLE: s_axi_rdata <= {28'h0000000, irq_enable_ff};
          `RBAC_ADDR_IRQ_CLEAR: s_axi_rdata <= 32'h00000000;
          `RBAC_ADDR_FRAME_CTRL: s_axi_rdata <= widen8({2'b00, state_ff, 1'b0, mem_raddr_ff})
              | widen8(8'h00) | {16'h0000, mem_rdata, 8'h00};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // control fields
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      keep_values_after_collision_ff <= 1'b0;
      receive_alignment_ff <= 3'h0;
      collision_as_integrity_error_ff <= 1'b0;
      irq_enable_ff <= 4'h0;
      mem_raddr_ff <= 3'h0;
    end else if (do_write && wstrb_ff[0]) begin
      if (awaddr_ff == `RBAC_ADDR_BIT_CONTROL) begin
        keep_values_after_collision_ff <= wdata_ff[`RBAC_KEEP_BIT];
        receive_alignment_ff <= wdata_ff[`RBAC_ALIGN_MSB:`RBAC_ALIGN_LSB];
        collision_as_integrity_error_ff <= wdata_ff[`RBAC_COLL_INTEG_BIT];
      end
      if (awaddr_ff == `RBAC_ADDR_IRQ_ENABLE) begin
        irq_enable_ff <= wdata_ff[3:0];
      end
      if (awaddr_ff == `RBAC_ADDR_FRAME_CTRL) begin
        mem_raddr_ff <= wdata_ff[6:4];
      end
    end
  end

  // ****************************************
  // receive framing
  // ****************************************
  logic rx_start, bit_take, stored_bit, byte_done, raw_coll, coll_event;
  assign rx_start = dec.start && state_ff == RBAC_WAIT;
  assign bit_take = dec.bit_valid && state_ff == RBAC_RECV;
  assign raw_coll = bit_take && dec.collision && !dec.in_eof; // RULE14
  assign coll_event = raw_coll && !coll_seen_ff;
  // unless keep_values_after_collision_ff is set, all bits after a collision, and the colliding bit, read as zero
  assign stored_bit = (coll_seen_ff || raw_coll) && !keep_values_after_collision_ff
      ? 1'b0 : dec.bit_value; // RULE1
  assign byte_done = bit_take && bpos_ff == 3'h7;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= RBAC_IDLE;
    end else begin
      case (state_ff)
        RBAC_IDLE: if (frame_arm) state_ff <= RBAC_WAIT;
        RBAC_WAIT: if (dec.start) state_ff <= RBAC_RECV;
        RBAC_RECV: if (dec.frame_end) state_ff <= RBAC_IDLE;
        default: state_ff <= RBAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_ff <= 8'h00;
      bpos_ff <= 3'h0;
      bit_idx_ff <= 7'h00;
      byte_cnt_ff <= 4'h0;
      byte_out <= '0;
      coll_seen_ff <= 1'b0;
    end else begin
      byte_out.valid <= 1'b0;
      if (rx_start) begin
        shift_ff <= 8'h00;
        bpos_ff <= receive_alignment_ff; // RULE2
        bit_idx_ff <= {4'h0, receive_alignment_ff}; // RULE12
        byte_cnt_ff <= 4'h0;
        coll_seen_ff <= 1'b0;
      end else if (bit_take) begin
        shift_ff[bpos_ff] <= stored_bit; // RULE2
        bpos_ff <= bpos_ff + 3'h1; // RULE3
        if (bit_idx_ff <= `RBAC_POS_LIMIT) begin
          bit_idx_ff <= bit_idx_ff + 7'h01;
        end
        if (raw_coll) coll_seen_ff <= 1'b1;
        if (byte_done) begin
          byte_out.valid <= 1'b1;
          byte_out.data <= {stored_bit, shift_ff[6:0]};
          shift_ff <= 8'h00;
          if (!byte_cnt_ff[3]) byte_cnt_ff <= byte_cnt_ff + 4'h1;
        end
      end else if (state_ff == RBAC_RECV && dec.frame_end && bpos_ff != 3'h0) begin
        byte_out.valid <= 1'b1; // partial last byte
        byte_out.data <= shift_ff;
      end
    end
  end

  rbac_byte_mem u_mem (
    .aclk(aclk),
    .we(byte_done && !byte_cnt_ff[3]),
    .waddr(byte_cnt_ff[2:0]),
    .wdata({stored_bit, shift_ff[6:0]}),
    .raddr(mem_raddr_ff),
    .rdata_ff(mem_rdata)
  );

  // ****************************************
  // status fields
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_byte_valid_bits_ff <= 3'h0;
    end else if (rx_start) begin
      last_byte_valid_bits_ff <= 3'h0; // RULE7
    end else if (state_ff == RBAC_RECV && dec.frame_end && receive_alignment_ff != 3'h0) begin
      last_byte_valid_bits_ff <= bpos_ff; // RULE4 RULE6 RULE7
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      collision_position_valid_ff <= 1'b0;
      collision_position_ff <= 7'h00;
      collision_detected_ff <= 1'b0;
      data_integrity_error_ff <= 1'b0;
    end else if (rx_start) begin
      collision_position_valid_ff <= 1'b0; // RULE16
      collision_position_ff <= 7'h00;
      collision_detected_ff <= 1'b0; // RULE15
      data_integrity_error_ff <= 1'b0;
    end else begin
      if (coll_event) begin
        collision_detected_ff <= 1'b1;
        collision_position_ff <= bit_idx_ff[6:0]; // RULE9 RULE10
        // past the eighth byte the index saturates above the limit
        collision_position_valid_ff <= bit_idx_ff <= `RBAC_POS_LIMIT; // RULE8 RULE11
      end
      if ((raw_coll && collision_as_integrity_error_ff) // RULE5
          || (state_ff == RBAC_RECV && dec.integ_err)) begin
        data_integrity_error_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // interrupts: set wins over clear
  // ****************************************
  logic [3:0] irq_set;
  assign irq_set = {data_integrity_error_ff, coll_event,
      state_ff == RBAC_RECV && dec.frame_end, byte_done};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_ff <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_set;
      irq <= |(((irq_status_ff & ~irq_clear) | irq_set) & irq_enable_ff);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence coll_hit_s; coll_event && collision_as_integrity_error_ff; endsequence
  coll_integ_a: assert property (coll_hit_s |=> data_integrity_error_ff) // RULE5
    else $error("collision did not raise integrity error");
  zero_after_a: assert property (bit_take && coll_seen_ff && !keep_values_after_collision_ff
      && !byte_done |=> shift_ff[$past(bpos_ff)] == 1'b0) // RULE1
    else $error("bit after collision not zero");
  align_start_a: assert property (rx_start |=> bpos_ff == $past(receive_alignment_ff)) // RULE2
    else $error("first bit position wrong");
  wrap_next_a: assert property (bit_take && bpos_ff == 3'h7 |=> bpos_ff == 3'h0) // RULE3
    else $error("bit position did not wrap");
  last_clr_a: assert property (rx_start |=> last_byte_valid_bits_ff == 3'h0) // RULE7
    else $error("last bits not reset at start");
  pos_valid_a: assert property (collision_position_valid_ff |-> collision_detected_ff
      && collision_position_ff <= 7'h3f) // RULE8 RULE11
    else $error("position valid out of range");
  eof_coll_a: assert property (bit_take && dec.in_eof && !coll_seen_ff
      |=> collision_detected_ff == $past(collision_detected_ff)) // RULE14
    else $error("collision flagged in end symbol");
  start_clear_a: assert property (rx_start |=> !collision_detected_ff
      && !collision_position_valid_ff) // RULE15 RULE16
    else $error("flags not cleared at start");
  pos_index_a: assert property (coll_event && bit_idx_ff <= 7'h3f
      |=> collision_position_ff == $past(bit_idx_ff)) // RULE9 RULE10 RULE12
    else $error("collision position wrong");
endmodule // rbac_rx_bit_align
`default_nettype wire

// ==== inc/rbac_cfg.svh ====
`ifndef RBAC_CFG_SVH
`define RBAC_CFG_SVH
// register indices; byte address is four times the index
`define RBAC_IDX_BIT_CONTROL 8'h0c
`define RBAC_IDX_COLL_INFO 8'h0d
`define RBAC_IDX_ERROR_FLAGS 8'h20
`define RBAC_IDX_IRQ_STATUS 8'h21
`define RBAC_IDX_IRQ_ENABLE 8'h22
`define RBAC_IDX_IRQ_CLEAR 8'h23
`define RBAC_IDX_FRAME_CTRL 8'h24
`define RBAC_ADDR_BIT_CONTROL 12'h030
`define RBAC_ADDR_COLL_INFO 12'h034
`define RBAC_ADDR_ERROR_FLAGS 12'h080
`define RBAC_ADDR_IRQ_STATUS 12'h084
`define RBAC_ADDR_IRQ_ENABLE 12'h088
`define RBAC_ADDR_IRQ_CLEAR 12'h08c
`define RBAC_ADDR_FRAME_CTRL 12'h090
// field positions
`define RBAC_KEEP_BIT 7
`define RBAC_ALIGN_MSB 6
`define RBAC_ALIGN_LSB 4
`define RBAC_COLL_INTEG_BIT 3
`define RBAC_LAST_MSB 2
`define RBAC_LAST_LSB 0
`define RBAC_CPV_BIT 7
`define RBAC_ERR_COLL_BIT 2
`define RBAC_ERR_INTEG_BIT 0
// interrupt bits: 0 byte complete (also past the eighth, unstored), 1 frame end, 2 collision, 3 integrity error
`define RBAC_IRQ_WIDTH 4
`define RBAC_CTRL_RESET 8'h00
`define RBAC_POS_LIMIT 7'h3f
`define RBAC_BYTE_DEPTH 8
`endif

// ==== inc/rbac_pkg.sv ====
package rbac_pkg;
  typedef enum logic [1:0] {
    RBAC_IDLE = 2'b00,
    RBAC_WAIT = 2'b01,
    RBAC_RECV = 2'b11
  } rbac_state_type;
  typedef struct packed {
    logic start;
    logic bit_valid;
    logic bit_value;
    logic collision;
    logic in_eof;
    logic frame_end;
    logic integ_err;
  } rbac_dec_type;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rbac_byte_type;
endpackage

// ==== verilog/rbac_byte_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
// small store of the first bytes of a frame, readable for debug
module rbac_byte_mem
  import rbac_pkg::*;
(
  input wire logic aclk,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] raddr,
  output logic [7:0] rdata_ff
);
  logic [7:0] mem_ff [0:7];
  always_ff @(posedge aclk) begin
    if (we) begin
      mem_ff[waddr] <= wdata;
    end
  end
  always_ff @(posedge aclk) begin
    rdata_ff <= mem_ff[raddr];
  end
endmodule // rbac_byte_mem
`default_nettype wire

// ==== verilog/rbac_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module rbac_sync
  import rbac_pkg::*;
#(
  parameter int W = 7
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_ff
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
endmodule // rbac_sync
`default_nettype wire

// ==== verif/rbac_card_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// card side of the receive decoder pins
// ****************
module rbac_card_model
  import rbac_pkg::*;
(
  input wire logic aclk,
  output rbac_dec_type dec
);
  initial begin
    dec = '0;
  end
  task automatic pulse_start();
    @(posedge aclk);
    dec.start <= 1'b1;
    @(posedge aclk);
    dec.start <= 1'b0;
  endtask
  task automatic pulse_end();
    @(posedge aclk);
    dec.frame_end <= 1'b1;
    @(posedge aclk);
    dec.frame_end <= 1'b0;
  endtask
  task automatic pulse_integ();
    @(posedge aclk);
    dec.integ_err <= 1'b1;
    @(posedge aclk);
    dec.integ_err <= 1'b0;
  endtask
  task automatic send_bit(input logic v, input logic c, input logic e);
    @(posedge aclk);
    dec.bit_valid <= 1'b1;
    dec.bit_value <= v;
    dec.collision <= c;
    dec.in_eof <= e;
    @(posedge aclk);
    dec.bit_valid <= 1'b0;
    dec.collision <= 1'b0;
    dec.in_eof <= 1'b0;
    // released line shows the inverse so a stale value cannot pass as data
    dec.bit_value <= ~v;
  endtask
endmodule // rbac_card_model
`default_nettype wire

// ==== verif/rx_bit_align_collision_bench.sv ====
`include "rbac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rx_bit_align_collision_bench
  import rbac_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  wire logic awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  rbac_dec_type dec;
  rbac_byte_type bout;
  int n_errors = 0;
  int samples_checked = 0;
  logic [7:0] got[$];
  logic [31:0] rd;
  logic [1:0] rr;
  always #2 aclk = ~aclk;
  rbac_card_model card (.aclk(aclk), .dec(dec));
  rbac_rx_bit_align uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dec_in(dec), .byte_out(bout), .irq(irq)
  );
  always @(posedge aclk) begin
    if (bout.valid === 1'b1) begin
      got.push_back(bout.data);
    end
  end
  // ****************
  // bus and compare helpers
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string what);
    axi_rd(a, rd, rr);
    check(rd & m, e, what);
  endtask
  // one armed frame; every bit from index ci on carries a collision
  task automatic frame(input logic [7:0] ctrl, input int n, input logic [127:0] v,
                       input int ci, input logic eof_c);
    logic c;
    axi_wr(`RBAC_ADDR_BIT_CONTROL, {24'h0, ctrl});
    axi_wr(`RBAC_ADDR_FRAME_CTRL, 32'h1);
    got.delete();
    card.pulse_start();
    repeat (3) @(posedge aclk);
    rd_chk(`RBAC_ADDR_BIT_CONTROL, 32'h7, 32'h0, "last bits at start");
    for (int i = 0; i < n; i++) begin
      c = (ci >= 0) && (i >= ci);
      card.send_bit(v[i], c, c && eof_c);
    end
    card.pulse_end();
    rd = 32'h30;
    while (rd[5:4] !== 2'b00) axi_rd(`RBAC_ADDR_FRAME_CTRL, rd, rr);
    repeat (2) @(posedge aclk);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    rd_chk(`RBAC_ADDR_BIT_CONTROL, 32'hff, 32'h00, "control reset");
    rd_chk(`RBAC_ADDR_COLL_INFO, 32'h80, 32'h00, "position valid reset");
    axi_rd(12'h0fc, rd, rr);
    check({30'h0, rr}, 32'h2, "unmapped resp");
    check(rd, 32'h0, "unmapped data");
    axi_wr(`RBAC_ADDR_BIT_CONTROL, 32'hff);
    check({30'h0, rr}, 32'h0, "mapped write resp");
    rd_chk(`RBAC_ADDR_BIT_CONTROL, 32'hff, 32'hf8, "last bits not writable");
    axi_wr(12'h0fc, 32'h0);
    check({30'h0, rr}, 32'h2, "unmapped write resp");
  endtask
  task automatic t_align4();
    axi_wr(`RBAC_ADDR_IRQ_ENABLE, 32'h4);
    frame(8'h48, 6, 128'h3f, 3, 1'b0);
    check(got.size(), 2, "byte count");
    check({24'h0, got[0]}, 32'h70, "first byte zeroed after collision");
    check({24'h0, got[1]}, 32'h00, "partial byte zeroed");
    rd_chk(`RBAC_ADDR_COLL_INFO, 32'hff, 32'h87, "position with offset");
    rd_chk(`RBAC_ADDR_ERROR_FLAGS, 32'h5, 32'h5, "collision as integrity");
    rd_chk(`RBAC_ADDR_BIT_CONTROL, 32'hff, 32'h4a, "last bits two");
    check({31'h0, irq}, 32'h1, "irq on collision");
    axi_wr(`RBAC_ADDR_IRQ_CLEAR, 32'h4);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0, "irq cleared");
  endtask
  task automatic t_byte_mode();
    frame(8'h00, 8, 128'ha5, -1, 1'b0);
    check(got.size(), 1, "one byte");
    check({24'h0, got[0]}, 32'ha5, "byte data");
    rd_chk(`RBAC_ADDR_BIT_CONTROL, 32'h7, 32'h0, "byte mode last bits");
    rd_chk(`RBAC_ADDR_COLL_INFO, 32'h80, 32'h00, "stale position cleared");
    rd_chk(`RBAC_ADDR_ERROR_FLAGS, 32'h5, 32'h0, "flags cleared at start");
    rd_chk(`RBAC_ADDR_FRAME_CTRL, 32'hff00, 32'ha500, "first byte stored");
    check({31'h0, irq}, 32'h0, "no irq without collision");
  endtask
  task automatic t_align7();
    axi_wr(`RBAC_ADDR_IRQ_ENABLE, 32'h0);
    frame(8'hf0, 2, 128'h3, 1, 1'b0);
    check(got.size(), 2, "two bytes");
    check({24'h0, got[0]}, 32'h80, "bit seven");
    check({24'h0, got[1]}, 32'h01, "wrap kept value");
    rd_chk(`RBAC_ADDR_COLL_INFO, 32'hff, 32'h88, "second byte first bit");
    rd_chk(`RBAC_ADDR_ERROR_FLAGS, 32'h5, 32'h4, "no integrity");
    rd_chk(`RBAC_ADDR_BIT_CONTROL, 32'hff, 32'hf1, "last bits one");
    rd_chk(`RBAC_ADDR_IRQ_STATUS, 32'h4, 32'h4, "status sticky");
    check({31'h0, irq}, 32'h0, "irq masked");
  endtask
  task automatic t_range();
    frame(8'h00, 64, 128'h7f00000000000000, 63, 1'b0);
    rd_chk(`RBAC_ADDR_COLL_INFO, 32'hff, 32'hbf, "last reportable bit");
    // point the debug read index at the eighth stored byte without arming
    axi_wr(`RBAC_ADDR_FRAME_CTRL, 32'h70);
    rd_chk(`RBAC_ADDR_FRAME_CTRL, 32'hff00, 32'h7f00, "eighth byte stored");
    frame(8'h00, 72, 128'h0, 64, 1'b0);
    rd_chk(`RBAC_ADDR_COLL_INFO, 32'h80, 32'h00, "beyond eight bytes");
    rd_chk(`RBAC_ADDR_ERROR_FLAGS, 32'h4, 32'h4, "collision still flagged");
  endtask
  task automatic t_eof();
    frame(8'h08, 8, 128'h0f, 7, 1'b1);
    rd_chk(`RBAC_ADDR_ERROR_FLAGS, 32'h5, 32'h0, "end symbol collision");
  endtask
  task automatic t_integ();
    axi_wr(`RBAC_ADDR_BIT_CONTROL, 32'h0);
    axi_wr(`RBAC_ADDR_FRAME_CTRL, 32'h1);
    card.pulse_start();
    card.send_bit(1'b1, 1'b0, 1'b0);
    card.pulse_integ();
    card.pulse_end();
    repeat (4) @(posedge aclk);
    rd_chk(`RBAC_ADDR_ERROR_FLAGS, 32'h5, 32'h1, "decoder integrity error");
    rd_chk(`RBAC_ADDR_IRQ_STATUS, 32'h8, 32'h8, "integrity status");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_align4();
    t_byte_mode();
    t_align7();
    t_range();
    t_eof();
    t_integ();
    final_report();
  end
  // a whole run needs fewer than a thousand cycles
  initial begin
    #200000;
    n_errors++;
    final_report();
  end
endmodule // rx_bit_align_collision_bench
`default_nettype wire
